/* File: dual_dac_serial_control.sv */
// Serial command receiver, double-buffered latches and shutdown control
`timescale 1ns/100ps
module dual_dac_serial_control (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic sdi_i,
  input wire logic load_outputs_n,
  input wire logic power_down_pin_n,
  output logic [11:0] first_channel_code_o,
  output logic first_channel_gain_select_n_o,
  output logic first_channel_ref_buffered_o,
  output logic first_channel_active_o,
  output logic [11:0] second_channel_code_o,
  output logic second_channel_gain_select_n_o,
  output logic second_channel_ref_buffered_o,
  output logic second_channel_active_o
);

  // ==========================================
  // Pin synchronisers
  // All three link pins and both strobes cross in through two flops.
  logic [4:0] meta_q;
  logic [4:0] sync_q;
  logic sck_prev_q;
  logic cs_prev_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // Idle levels: strobes and chip select high, serial clock and data low
      meta_q <= 5'h19;
      sync_q <= 5'h19;
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else if (ce_i) begin
      meta_q <= {power_down_pin_n, load_outputs_n, sdi_i, sck_i, cs_n_i};
      sync_q <= meta_q;
      sck_prev_q <= sync_q[1];
      cs_prev_q <= sync_q[0];
    end
  end

  wire cs_n_s = sync_q[0];
  wire sck_s = sync_q[1];
  wire sdi_s = sync_q[2];
  wire load_n_s = sync_q[3];
  wire pd_n_s = sync_q[4];
  // Only rising clock edges matter, so idle-high (1,1) and idle-low (0,0) both work
  wire sck_rise = sck_s && !sck_prev_q;
  wire cs_rise = cs_n_s && !cs_prev_q;

  // ==========================================
  // Shifter
  logic [15:0] shift_q;
  logic [15:0] shift_d;
  logic [4:0] count_q;
  logic [4:0] count_d;
  dac_ctl_pkg::link_state_t state_q;
  dac_ctl_pkg::link_state_t state_d;
  wire word_full = (count_q == dac_ctl_pkg::FULL_COUNT);
  wire take_bit = (state_q == dac_ctl_pkg::LINK_SHIFT) && !cs_n_s && sck_rise
    && !word_full;
  wire word_done = (state_q == dac_ctl_pkg::LINK_SHIFT) && cs_rise && word_full;

  always_comb begin
    state_d = state_q;
    shift_d = shift_q;
    count_d = count_q;
    unique case (state_q)
      dac_ctl_pkg::LINK_IDLE: begin
        if (!cs_n_s) begin
          state_d = dac_ctl_pkg::LINK_SHIFT;
          count_d = 5'h00;
          if (sck_rise) begin
            shift_d = {shift_q[14:0], sdi_s};
            count_d = 5'h01;
          end
        end
      end
      dac_ctl_pkg::LINK_SHIFT: begin
        if (cs_n_s) begin
          // Short word is dropped here without touching the latches
          state_d = dac_ctl_pkg::LINK_IDLE;
          count_d = 5'h00;
        end else if (take_bit) begin
          shift_d = {shift_q[14:0], sdi_s};
          count_d = count_q + 5'h01;
        end
      end
    endcase
  end

  // Receiver runs whatever the shutdown state is
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= dac_ctl_pkg::LINK_IDLE;
      shift_q <= 16'h0000;
      count_q <= 5'h00;
    end else if (ce_i) begin
      state_q <= state_d;
      shift_q <= shift_d;
      count_q <= count_d;
    end
  end

  // ==========================================
  // Command decode
  dac_ctl_pkg::chan_cfg_t word_cfg;
  assign word_cfg.ref_buffered = shift_q[dac_ctl_pkg::BUF_BIT];
  assign word_cfg.gain_select_n = shift_q[dac_ctl_pkg::GAIN_BIT];
  assign word_cfg.output_active_ctl = shift_q[dac_ctl_pkg::ACTIVE_BIT];
  assign word_cfg.code_word = shift_q[dac_ctl_pkg::CODE_BITS-1:0];
  wire word_sel = shift_q[dac_ctl_pkg::CHAN_BIT];

  dac_ctl_pkg::chan_cfg_t in_cfg [2];

  dac_input_latches u_latches (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .wr_i(word_done),
    .wr_sel_i(word_sel),
    .wr_cfg_i(word_cfg),
    .rd_cfg_o(in_cfg)
  );

  // Marks a channel whose input latch holds a word not yet seen at reset
  logic [1:0] written_q;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      written_q <= 2'h0;
    end else if (ce_i && word_done) begin
      written_q[word_sel] <= 1'b1;
    end
  end

  // ==========================================
  // Output latches
  // Level sensitive: a new input word passes straight through while strobe is low.
  dac_ctl_pkg::chan_cfg_t out_q [2];
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_out
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          out_q[g] <= dac_ctl_pkg::CFG_RESET;
        end else if (ce_i && !load_n_s && written_q[g]) begin
          out_q[g] <= in_cfg[g];
        end
      end
    end
  endgenerate

  // ==========================================
  // Output registers
  // Pin shutdown overrides the written control; pin high restores it without a new write.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      first_channel_code_o <= 12'h000;
      first_channel_gain_select_n_o <= 1'b0;
      first_channel_ref_buffered_o <= 1'b0;
      first_channel_active_o <= 1'b0;
      second_channel_code_o <= 12'h000;
      second_channel_gain_select_n_o <= 1'b0;
      second_channel_ref_buffered_o <= 1'b0;
      second_channel_active_o <= 1'b0;
    end else if (ce_i) begin
      first_channel_code_o <= out_q[0].code_word;
      first_channel_gain_select_n_o <= out_q[0].gain_select_n;
      first_channel_ref_buffered_o <= out_q[0].ref_buffered;
      first_channel_active_o <= out_q[0].output_active_ctl && pd_n_s;
      second_channel_code_o <= out_q[1].code_word;
      second_channel_gain_select_n_o <= out_q[1].gain_select_n;
      second_channel_ref_buffered_o <= out_q[1].ref_buffered;
      second_channel_active_o <= out_q[1].output_active_ctl && pd_n_s;
    end
  end

  // No serial output exists on this block

endmodule // dual_dac_serial_control

/* File: dac_ctl_pkg.sv */
// Package with constants and types for the dual-channel serial DAC control block
// Function
// - Link is accepted only while chip select is low; otherwise ignored.
// - While load strobe low, each input latch is copied to its output latch.
// - Low on shutdown pin puts every channel into standby.
// - Twelve data bits are an unsigned straight-binary code.
// - Gain select bit 1 means unity gain, 0 means gain of two.
// - After reset each channel's gain selection is gain of two.
// - Each channel keeps its own reference buffer selection.
// - After reset each reference buffer selection is unbuffered bypass.
// - After reset every channel's output-active control is cleared.
// - Outputs stay off until a write is latched and load strobe goes low.
// - Reset holds channels; leaving needs reset release then a later write.
// - Shutdown comes from the pin or a written output-active value of 0.
// - Serial receiver keeps working during shutdown.
// - Shutdown lasts until pin high and output-active 1 latched, before or after the pin rises.
// - Link runs in clock mode 0,0 or 1,1; device accepts both.
// - Data is sampled on each rising serial clock edge.
// - Link is write-only; no serial output, no read-back.
// - Each command is exactly one 16-bit word.
// - MSB first: channel, buffer, gain_n, output-active, twelve data bits.
// - Serial clock edges after the sixteenth are ignored.
// - Chip select rising before sixteen clocks discards the partial word.
// - On chip-select rise after sixteen clocks, word goes to selected channel.
package dac_ctl_pkg;

  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned CODE_BITS = 12;
  localparam int unsigned CNT_BITS = 5;
  localparam logic [CNT_BITS-1:0] FULL_COUNT = 5'h10;
  localparam int unsigned CHAN_BIT = 15;
  localparam int unsigned BUF_BIT = 14;
  localparam int unsigned GAIN_BIT = 13;
  localparam int unsigned ACTIVE_BIT = 12;

  // One channel's latched settings
  typedef struct packed {
    logic ref_buffered;
    logic gain_select_n;
    logic output_active_ctl;
    logic [CODE_BITS-1:0] code_word;
  } chan_cfg_t;

  localparam chan_cfg_t CFG_RESET = '{
    ref_buffered: 1'b0,
    gain_select_n: 1'b0,
    output_active_ctl: 1'b0,
    code_word: 12'h000
  };

  typedef enum logic {
    LINK_IDLE,
    LINK_SHIFT
  } link_state_t;

endpackage

/* File: dac_input_latches.sv */
// Per-channel input latch storage with registered read data
`timescale 1ns/100ps
module dac_input_latches (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic wr_sel_i,
  input wire dac_ctl_pkg::chan_cfg_t wr_cfg_i,
  output dac_ctl_pkg::chan_cfg_t rd_cfg_o [2]
);

  // ==========================================
  // Storage
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          rd_cfg_o[g] <= dac_ctl_pkg::CFG_RESET;
        end else if (ce_i && wr_i && (wr_sel_i == 1'(g))) begin
          rd_cfg_o[g] <= wr_cfg_i;
        end
      end
    end
  endgenerate

endmodule // dac_input_latches

/* File: dac_ctl_props.sv */
// Concurrent checks on the serial DAC control block ports
`timescale 1ns/100ps
module dac_ctl_props (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cs_n_i,
  input wire logic load_outputs_n,
  input wire logic power_down_pin_n,
  input wire logic [11:0] first_channel_code_o,
  input wire logic first_channel_gain_select_n_o,
  input wire logic first_channel_ref_buffered_o,
  input wire logic first_channel_active_o,
  input wire logic [11:0] second_channel_code_o,
  input wire logic second_channel_active_o
);
  // =====
  // History of strobe and chip select, deep enough to span the sync latency
  logic [7:0] ld_hist_q;
  logic [7:0] cs_hist_q;
  wire cs_rose_recent = |(~cs_hist_q[7:1] & cs_hist_q[6:0]);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ld_hist_q <= 8'h00;
      cs_hist_q <= 8'hFF;
    end else begin
      ld_hist_q <= {ld_hist_q[6:0], !load_outputs_n};
      cs_hist_q <= {cs_hist_q[6:0], cs_n_i};
    end
  end
  // =====
  // Assertions
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  AST_RESET_DEFAULTS: assert property ($rose(resetn_i) |-> !first_channel_gain_select_n_o &&
    !first_channel_ref_buffered_o && !first_channel_active_o) else $error("reset defaults");
  AST_PIN_STANDBY: assert property (!power_down_pin_n [*4] |->
    !(first_channel_active_o || second_channel_active_o)) else $error("active in standby");
  AST_FIRST_NEEDS_STROBE: assert property ($changed(first_channel_code_o) |-> |ld_hist_q)
    else $error("first code moved without strobe");
  AST_SECOND_NEEDS_STROBE: assert property ($changed(second_channel_code_o) |-> |ld_hist_q)
    else $error("second code moved without strobe");
  AST_FOLLOWS_CS_RISE: assert property (ld_hist_q == 8'hFF &&
    $changed(first_channel_code_o) |-> cs_rose_recent) else $error("code moved without word");
  AST_ACTIVE_NEEDS_LOAD: assert property ($rose(first_channel_active_o) |-> |ld_hist_q)
    else $error("output active without strobe");
  AST_ACTIVE_NEEDS_PIN: assert property ($rose(second_channel_active_o) |->
    $past(power_down_pin_n, 3)) else $error("output active with pin low");
  AST_PIN_DROPS_ACTIVE: assert property ($fell(power_down_pin_n) |->
    ##[1:4] !first_channel_active_o) else $error("pin shutdown not seen");
  cover property ($rose(cs_n_i) && !load_outputs_n);
  cover property ($rose(first_channel_active_o));
  cover property (!power_down_pin_n && !cs_n_i);
endmodule // dac_ctl_props
bind dual_dac_serial_control dac_ctl_props i_props (.*);

/* File: spi_host_model.sv */
// Serial host model that sends command words on the link
`timescale 1ns/100ps
module spi_host_model (
  output logic cs_n_o,
  output logic sck_o,
  output logic sdi_o
);
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  // =====
  // Sends n bits MSB first, 32 ns link period; clock idles at the mode level
  task automatic send(input logic [15:0] w, input int n, input bit mode11);
    sck_o = mode11;
    #64 cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      sck_o = 1'b0;
      sdi_o = w[15 - (i % 16)];
      #16 sck_o = 1'b1;
      #16;
    end
    sck_o = mode11;
    #16 cs_n_o = 1'b1;
    // Released data line shows no stale bit
    sdi_o = ~sdi_o;
  endtask
endmodule // spi_host_model

/* File: testbench.sv */
// Self-checking bench for the serial DAC control block
`timescale 1ns/100ps
module testbench;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ld_n = 1'b1;
  logic pd_n = 1'b1;
  logic ce = 1'b1;
  wire cs_n, sck, sdi;
  dac_ctl_pkg::chan_cfg_t ch0, ch1;
  int failures = 0;
  int compares = 0;
  always #2 clk_i = ~clk_i;
  spi_host_model i_host (.cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi));
  dual_dac_serial_control i_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce), .cs_n_i(cs_n), .sck_i(sck), .sdi_i(sdi),
    .load_outputs_n(ld_n), .power_down_pin_n(pd_n),
    .first_channel_code_o(ch0.code_word), .first_channel_gain_select_n_o(ch0.gain_select_n),
    .first_channel_ref_buffered_o(ch0.ref_buffered), .first_channel_active_o(ch0.output_active_ctl),
    .second_channel_code_o(ch1.code_word), .second_channel_gain_select_n_o(ch1.gain_select_n),
    .second_channel_ref_buffered_o(ch1.ref_buffered),
    .second_channel_active_o(ch1.output_active_ctl));
  // =====
  // Tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input dac_ctl_pkg::chan_cfg_t got, input dac_ctl_pkg::chan_cfg_t exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Output settles about five cycles after chip select rises
  task automatic wr(input logic [15:0] w, input int n, input bit mode11);
    i_host.send(w, n, mode11);
    step(12);
  endtask
  task automatic report_and_stop;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // =====
  // Sequence
  initial begin
    step(4);
    resetn_i = 1'b1;
    step(4);
    chk(ch0, 15'h0000);
    chk(ch1, 15'h0000);
    wr(16'h7ABC, 16, 1'b0);
    chk(ch0, 15'h0000);
    ld_n = 1'b0;
    step(8);
    chk(ch0, 15'h7ABC);
    chk(ch1, 15'h0000);
    wr(16'hD123, 16, 1'b1);
    chk(ch1, 15'h5123);
    chk(ch0, 15'h7ABC);
    wr(16'h0FFF, 15, 1'b0);
    chk(ch0, 15'h7ABC);
    wr(16'h2F0F, 20, 1'b0);
    chk(ch0, 15'h2F0F);
    pd_n = 1'b0;
    wr(16'h1000, 16, 1'b0);
    chk(ch0, 15'h0000);
    pd_n = 1'b1;
    step(8);
    chk(ch0, 15'h1000);
    resetn_i = 1'b0;
    step(2);
    chk(ch1, 15'h0000);
    resetn_i = 1'b1;
    step(8);
    chk(ch0, 15'h0000);
    wr(16'h9FFF, 16, 1'b1);
    chk(ch1, 15'h1FFF);
    // A word sent while the clock enable is low must leave no trace
    ce = 1'b0;
    wr(16'h3555, 16, 1'b0);
    ce = 1'b1;
    step(8);
    chk(ch0, 15'h0000);
    chk(ch1, 15'h1FFF);
    report_and_stop();
  end
  initial begin
    #100000;
    failures++;
    report_and_stop();
  end
endmodule // testbench
